// ==== include/ims_defines.svh ====
// Constants of the interface mode selection block: addresses, field positions, reset values and counts.
`ifndef IMS_DEFINES_SVH
`define IMS_DEFINES_SVH

// ----------------------------------------------------------------------
// Host register access
// ----------------------------------------------------------------------
`define IMS_HOST_ADDR_WIDTH 8
`define IMS_HOST_DATA_WIDTH 16
`define IMS_ADDR_MODE_SELECT 8'h01
`define IMS_RESET_VALUE 10'h000
`define IMS_READ_IDLE 16'h0000
`define IMS_UNUSED_ZERO 6'h00

// ----------------------------------------------------------------------
// Field positions of the mode selection register
// ----------------------------------------------------------------------
`define IMS_USED_HI 9
`define IMS_USED_LO 0
`define IMS_BIT_SFE 2
`define IMS_BIT_BPE 4

// ----------------------------------------------------------------------
// Serial rate codes
// ----------------------------------------------------------------------
`define IMS_RATE_CODE_2M 2'h0
`define IMS_RATE_CODE_4M 2'h1
`define IMS_RATE_CODE_8M 2'h2

// ----------------------------------------------------------------------
// Connection memory and block fill
// ----------------------------------------------------------------------
`define CM_ADDR_WIDTH 11
`define CM_DEPTH 2048
`define CM_LOW_BITS_CLEAR 11'h000
`define FILL_FRAMES 2
`define FILL_FRAME_CNT_WIDTH 2
`define SERIAL_OUTPUTS 16

`endif

// ==== include/ims_pkg.sv ====
// Types shared by the interface mode selection block.
package ims_pkg;

	// Bits 9 to 0 of the mode selection register, in register order.
	typedef struct packed {
		logic [4:0] block_fill_data;
		logic block_fill_begin;
		logic output_standby;
		logic start_offset_evaluation;
		logic [1:0] serial_rate_select;
	} mode_fields_t;

	// One write into the connection memory.
	typedef struct packed {
		logic wr_en;
		logic [10:0] addr;
		logic [15:0] data;
	} cm_write_t;

	// Decoded serial rate; the master clock required is twice the bit rate.
	typedef enum logic [2:0] {
		RATE_2M048 = 3'b001,
		RATE_4M096 = 3'b010,
		RATE_8M192 = 3'b100
	} serial_rate_t;

	typedef enum logic [2:0] {
		FILL_IDLE = 3'b001,
		FILL_SWEEP = 3'b010,
		FILL_HOLD = 3'b100
	} fill_state_t;

endpackage : ims_pkg

// ==== rtl/ims_sync.sv ====
// Three-stage synchroniser for a level from a pin, with agreement filter.
`timescale 1ns/1ns
`default_nettype none

module ims_sync (
	input wire logic core_clk_in, // Core clock.
	input wire logic rst_n_in, // Synchronised reset, active low.
	input wire logic async_in, // Level from outside the clock domain.
	output logic level_out // Filtered level.
);
	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// A change counts only once the last two stages agree.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_out <= 1'b0;
		end else if (stage2_reg == stage3_reg) begin
			level_out <= stage3_reg;
		end
	end

endmodule : ims_sync

`default_nettype wire

// ==== rtl/block_fill_engine.sv ====
// Connection memory block fill: sweeps every word and holds for the frame count.
`timescale 1ns/1ns
`default_nettype none
`include "ims_defines.svh"

module block_fill_engine #(
	parameter int DEPTH = `CM_DEPTH,
	parameter int FRAMES = `FILL_FRAMES
) (
	input wire logic core_clk_in, // Core clock.
	input wire logic rst_n_in, // Synchronised reset, active low.
	input wire logic start_in, // One-cycle start pulse.
	input wire logic abort_in, // One-cycle abort pulse.
	input wire logic frame_start_in, // One-cycle frame boundary pulse.
	input wire logic [4:0] fill_data_in, // Value for the top five bits.
	output ims_pkg::cm_write_t cm_write_out, // Registered memory write.
	output logic busy_out, // High while filling.
	output logic done_out // One-cycle pulse on completion.
);
	import ims_pkg::*;

	localparam logic [`CM_ADDR_WIDTH-1:0] LAST_ADDR = `CM_ADDR_WIDTH'(DEPTH - 1);
	localparam logic [`FILL_FRAME_CNT_WIDTH-1:0] FRAME_TARGET = `FILL_FRAME_CNT_WIDTH'(FRAMES);

	if (DEPTH < 1 || DEPTH > (1 << `CM_ADDR_WIDTH) || FRAMES < 1 || FRAMES > 3) begin : g_param_check
		$error("block_fill_engine: DEPTH or FRAMES out of range");
	end

	fill_state_t state_reg;
	logic [`CM_ADDR_WIDTH-1:0] addr_reg;
	logic [`FILL_FRAME_CNT_WIDTH-1:0] frame_cnt_reg;
	logic [4:0] data_reg;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= FILL_IDLE;
			addr_reg <= '0;
			data_reg <= '0;
		end else begin
			case (state_reg)
				FILL_IDLE: begin
					if (start_in) begin
						state_reg <= FILL_SWEEP;
						addr_reg <= '0;
						data_reg <= fill_data_in;
					end
				end
				FILL_SWEEP: begin
					if (abort_in) begin
						state_reg <= FILL_IDLE;
					end else if (addr_reg == LAST_ADDR) begin
						state_reg <= FILL_HOLD;
					end else begin
						addr_reg <= addr_reg + 1'b1;
					end
				end
				FILL_HOLD: begin
					if (abort_in || frame_cnt_reg == FRAME_TARGET) begin
						state_reg <= FILL_IDLE;
					end
				end
				default: begin
					state_reg <= FILL_IDLE;
				end
			endcase
		end
	end

	// Frames are counted from the start; completion waits for both the sweep and the count.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_cnt_reg <= '0;
		end else if (state_reg == FILL_IDLE) begin
			frame_cnt_reg <= '0;
		end else if (frame_start_in && frame_cnt_reg != FRAME_TARGET) begin
			frame_cnt_reg <= frame_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cm_write_out <= '0;
		end else begin
			cm_write_out.wr_en <= (state_reg == FILL_SWEEP) && !abort_in;
			cm_write_out.addr <= addr_reg;
			cm_write_out.data <= {data_reg, `CM_LOW_BITS_CLEAR}; // R2 R3
		end
	end

	assign busy_out = (state_reg != FILL_IDLE);
	assign done_out = (state_reg == FILL_HOLD) && !abort_in && (frame_cnt_reg == FRAME_TARGET); // R6

endmodule : block_fill_engine

`default_nettype wire

// ==== rtl/interface_mode_select.sv ====
// Interface mode selection register with block fill, output standby, offset evaluation and rate control.
//
// Overview of operation
// R1: Host writes zeros to bits fifteen to ten.
// R2: Fill copies data into top five bits.
// R3: Fill clears lower eleven bits of words.
// R4: Begin rising edge starts fill when ready.
// R5: Host sets begin and data together.
// R6: Fill takes two full frames to finish; the code ends it after the second frame pulse from the start.
// R7: Device clears begin bit when fill ends.
// R8: Clearing begin or ready aborts fill.
// R9: Host holds other bits for two frames.
// R10: Pin low, standby zero: outputs high impedance.
// R11: Pin high or standby one: outputs drive.
// R12: Evaluation bit rising edge starts offset measurement.
// R13: Evaluation stops when complete flag rises.
// R14: Host holds evaluation bit low one frame.
// R15: Rate field selects 2, 4, 8 Mb/s.
// R16: Reserved rate code behaves as 2 Mb/s.
// R17: Ready bit arms or disables the fill.
// R18: Complete flag clears on evaluation bit fall.
`timescale 1ns/1ns
`default_nettype none
`include "ims_defines.svh"

module interface_mode_select #(
	parameter int CM_DEPTH = `CM_DEPTH,
	parameter int FILL_FRAMES = `FILL_FRAMES,
	parameter int SERIAL_OUTPUTS = `SERIAL_OUTPUTS
) (
	input wire logic core_clk_in, // Master clock, 20 MHz.
	input wire logic rst_n_in, // Reset, active low, asynchronous.
	input wire logic host_sel_in, // Host access strobe, one cycle.
	input wire logic host_wr_in, // High for write, low for read.
	input wire logic [`IMS_HOST_ADDR_WIDTH-1:0] host_addr_in, // Register address.
	input wire logic [`IMS_HOST_DATA_WIDTH-1:0] host_wdata_in, // Write data.
	output logic [`IMS_HOST_DATA_WIDTH-1:0] host_rdata_out, // Registered read data.
	output logic host_rd_hit_out, // Read data valid for this register.
	input wire logic block_fill_ready_in, // Ready bit from the control register.
	input wire logic frame_start_in, // Frame boundary pulse, same clock.
	input wire logic output_drive_enable_pin_in, // Output drive enable pin, asynchronous.
	input wire logic offset_evaluation_complete_in, // Complete flag from the evaluator, same clock.
	output ims_pkg::cm_write_t cm_write_out, // Connection memory write port.
	output logic block_fill_busy_out, // Fill in progress.
	output logic [SERIAL_OUTPUTS-1:0] serial_output_enable_out, // Per-stream driver enable.
	output logic offset_eval_start_out, // One-cycle start of measurement.
	output logic offset_eval_active_out, // Measurement running.
	output logic offset_eval_clear_out, // One-cycle clear of result and flag.
	output ims_pkg::serial_rate_t serial_rate_out // Selected serial rate.
);
	import ims_pkg::*;

	if (SERIAL_OUTPUTS < 1 || SERIAL_OUTPUTS > `SERIAL_OUTPUTS) begin : g_param_check
		$error("interface_mode_select: SERIAL_OUTPUTS out of range");
	end

	// ----------------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------------
	// Host access decode
	// ----------------------------------------------------------------------
	logic addr_hit;
	logic write_hit;
	logic read_hit;
	mode_fields_t wr_fields;
	mode_fields_t mode_reg;

	assign addr_hit = host_sel_in && (host_addr_in == `IMS_ADDR_MODE_SELECT);
	assign write_hit = addr_hit && host_wr_in;
	assign read_hit = addr_hit && !host_wr_in;
	// Bits above the used field are dropped; the host keeps them zero.
	assign wr_fields = mode_fields_t'(host_wdata_in[`IMS_USED_HI:`IMS_USED_LO]); // R1

	// ----------------------------------------------------------------------
	// Block fill control
	// ----------------------------------------------------------------------
	logic fill_start;
	logic fill_abort;
	logic fill_done;
	logic fill_busy;
	logic ready_prev_reg;
	logic ready_fall;

	assign ready_fall = ready_prev_reg && !block_fill_ready_in;

	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ready_prev_reg <= 1'b0;
		end else begin
			ready_prev_reg <= block_fill_ready_in;
		end
	end

	// Begin data and begin bit come from the same write, so the data is taken with the edge.
	assign fill_start = write_hit && wr_fields.block_fill_begin && !mode_reg.block_fill_begin
		&& block_fill_ready_in; // R4 R5 R17

	// A write with begin low or a drop of the ready bit ends a running fill.
	assign fill_abort = fill_busy && ((write_hit && !wr_fields.block_fill_begin)
		|| !block_fill_ready_in); // R8 R17

	block_fill_engine #(
		.DEPTH(CM_DEPTH),
		.FRAMES(FILL_FRAMES)
	) u_fill (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_sync_reg),
		.start_in(fill_start),
		.abort_in(fill_abort),
		.frame_start_in(frame_start_in),
		.fill_data_in(wr_fields.block_fill_data),
		.cm_write_out(cm_write_out),
		.busy_out(fill_busy),
		.done_out(fill_done)
	);

	assign block_fill_busy_out = fill_busy;

	// ----------------------------------------------------------------------
	// Mode selection register
	// ----------------------------------------------------------------------
	// A host write in the same cycle as completion wins; its begin bit is kept but starts no new fill.
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			mode_reg <= mode_fields_t'(`IMS_RESET_VALUE);
		end else if (write_hit) begin
			mode_reg <= wr_fields;
		end else if (fill_done) begin
			mode_reg.block_fill_begin <= 1'b0; // R7
		end else if (fill_busy && ready_fall) begin
			mode_reg.block_fill_begin <= 1'b0; // R8
		end
	end

	// ----------------------------------------------------------------------
	// Register readback
	// ----------------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			host_rdata_out <= `IMS_READ_IDLE;
			host_rd_hit_out <= 1'b0;
		end else if (read_hit) begin
			host_rdata_out <= {`IMS_UNUSED_ZERO, mode_reg};
			host_rd_hit_out <= 1'b1;
		end else begin
			host_rdata_out <= `IMS_READ_IDLE;
			host_rd_hit_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// Output standby
	// ----------------------------------------------------------------------
	logic drive_pin_level;
	logic drive_on;

	ims_sync u_drive_sync (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_sync_reg),
		.async_in(output_drive_enable_pin_in),
		.level_out(drive_pin_level)
	);

	// Per-channel enables from the connection memory are applied downstream of this mask.
	assign drive_on = drive_pin_level || mode_reg.output_standby; // R10 R11

	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			serial_output_enable_out <= '0;
		end else begin
			serial_output_enable_out <= {SERIAL_OUTPUTS{drive_on}}; // R10 R11
		end
	end

	// ----------------------------------------------------------------------
	// Frame offset evaluation
	// ----------------------------------------------------------------------
	logic eval_rise;
	logic eval_fall;
	logic complete_prev_reg;
	logic complete_rise;

	assign eval_rise = write_hit && wr_fields.start_offset_evaluation && !mode_reg.start_offset_evaluation;
	assign eval_fall = write_hit && !wr_fields.start_offset_evaluation && mode_reg.start_offset_evaluation;
	assign complete_rise = offset_evaluation_complete_in && !complete_prev_reg;

	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			complete_prev_reg <= 1'b0;
		end else begin
			complete_prev_reg <= offset_evaluation_complete_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			offset_eval_start_out <= 1'b0;
			offset_eval_clear_out <= 1'b0;
		end else begin
			offset_eval_start_out <= eval_rise; // R12
			offset_eval_clear_out <= eval_fall; // R18
		end
	end

	// A new start beats a completion seen in the same cycle.
	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			offset_eval_active_out <= 1'b0;
		end else if (eval_rise) begin
			offset_eval_active_out <= 1'b1; // R12
		end else if (complete_rise || eval_fall) begin
			offset_eval_active_out <= 1'b0; // R13
		end
	end

	// ----------------------------------------------------------------------
	// Serial rate selection
	// ----------------------------------------------------------------------
	function automatic serial_rate_t decode_rate(input logic [1:0] code);
		case (code)
			`IMS_RATE_CODE_2M: decode_rate = RATE_2M048;
			`IMS_RATE_CODE_4M: decode_rate = RATE_4M096;
			`IMS_RATE_CODE_8M: decode_rate = RATE_8M192;
			default: decode_rate = RATE_2M048; // R16
		endcase
	endfunction : decode_rate

	always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			serial_rate_out <= RATE_2M048;
		end else begin
			serial_rate_out <= decode_rate(mode_reg.serial_rate_select); // R15
		end
	end

endmodule : interface_mode_select

`default_nettype wire

// ==== verification/interface_mode_select_checker.sv ====
// Concurrent checks on the ports of the interface mode selection block.
`timescale 1ns/1ns
`default_nettype none
`include "ims_defines.svh"
module interface_mode_select_checker #(
	parameter int CM_DEPTH = `CM_DEPTH,
	parameter int FILL_FRAMES = `FILL_FRAMES,
	parameter int SERIAL_OUTPUTS = `SERIAL_OUTPUTS
) (
	input wire logic core_clk_in, // Clock.
	input wire logic rst_n_in, // Reset.
	input wire logic host_sel_in, // Strobe.
	input wire logic host_wr_in, // Write.
	input wire logic [7:0] host_addr_in, // Address.
	input wire logic [15:0] host_wdata_in, // Write data.
	input wire logic [15:0] host_rdata_out, // Read data.
	input wire logic host_rd_hit_out, // Read hit.
	input wire logic block_fill_ready_in, // Ready bit.
	input wire logic frame_start_in, // Frame pulse.
	input wire logic output_drive_enable_pin_in, // Drive pin.
	input wire logic offset_evaluation_complete_in, // Complete flag.
	input wire ims_pkg::cm_write_t cm_write_out, // Memory write.
	input wire logic block_fill_busy_out, // Busy.
	input wire logic [SERIAL_OUTPUTS-1:0] serial_output_enable_out, // Enables.
	input wire logic offset_eval_start_out, // Start pulse.
	input wire logic offset_eval_active_out, // Active.
	input wire logic offset_eval_clear_out, // Clear pulse.
	input wire ims_pkg::serial_rate_t serial_rate_out // Rate.
);
	import ims_pkg::*;
	logic hit_wr, start_req, abort_wr, eval_rise, osb_q, sfe_q, aborted;
	logic [4:0] fill_q;
	logic [1:0] rate_q;
	logic [11:0] wcnt;
	logic [3:0] fcnt;
	assign hit_wr = host_sel_in && host_wr_in && host_addr_in == `IMS_ADDR_MODE_SELECT;
	assign start_req = hit_wr && host_wdata_in[4] && block_fill_ready_in;
	assign abort_wr = hit_wr && !host_wdata_in[4];
	assign eval_rise = hit_wr && host_wdata_in[2] && !sfe_q;
	function automatic serial_rate_t rate_enc(input logic [1:0] c);
		case (c)
			2'h1: return RATE_4M096;
			2'h2: return RATE_8M192;
			default: return RATE_2M048;
		endcase
	endfunction : rate_enc
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fill_q <= 5'h00;
			osb_q <= 1'b0;
			sfe_q <= 1'b0;
			rate_q <= 2'h0;
		end else if (hit_wr) begin
			fill_q <= host_wdata_in[9:5];
			osb_q <= host_wdata_in[3];
			sfe_q <= host_wdata_in[2];
			rate_q <= host_wdata_in[1:0];
		end
	end
	// Sticky abort flag keeps aborted fills out of the completion check.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wcnt <= 12'h000;
			fcnt <= 4'h0;
			aborted <= 1'b0;
		end else if (start_req) begin
			wcnt <= 12'h000;
			fcnt <= 4'h0;
			aborted <= 1'b0;
		end else begin
			wcnt <= wcnt + 12'(cm_write_out.wr_en);
			fcnt <= fcnt + 4'(frame_start_in && block_fill_busy_out);
			aborted <= aborted || abort_wr || !block_fill_ready_in;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_FILL_LOW: assert property (cm_write_out.wr_en |-> cm_write_out.data[10:0] == 11'h000)
		else $error("fill word low bits not clear");
	AST_FILL_HIGH: assert property (cm_write_out.wr_en |-> cm_write_out.data[15:11] == fill_q
		&& cm_write_out.addr == wcnt[10:0]) else $error("fill word data or address wrong");
	AST_FILL_START: assert property ($rose(block_fill_busy_out) |-> $past(start_req))
		else $error("fill started without armed begin write");
	AST_FILL_FRAMES: assert property ($fell(block_fill_busy_out) && !aborted |->
		fcnt >= FILL_FRAMES && wcnt == CM_DEPTH) else $error("fill ended early");
	AST_FILL_ABORT: assert property (abort_wr && block_fill_busy_out |-> ##2 !block_fill_busy_out
		##1 !cm_write_out.wr_en) else $error("fill not aborted by write");
	AST_READY_OFF: assert property (!block_fill_ready_in |-> ##2 !block_fill_busy_out ##1 !cm_write_out.wr_en)
		else $error("fill running without ready");
	AST_EVAL_START: assert property (eval_rise |=> offset_eval_start_out && offset_eval_active_out)
		else $error("evaluation did not start");
	AST_EVAL_CLEAR: assert property (hit_wr && !host_wdata_in[2] && sfe_q |=>
		offset_eval_clear_out && !offset_eval_active_out) else $error("evaluation not cleared");
	AST_EVAL_STOP: assert property ($rose(offset_evaluation_complete_in) && !offset_eval_start_out
		&& !eval_rise |=> !offset_eval_active_out) else $error("evaluation did not stop");
	AST_HI_Z: assert property (!output_drive_enable_pin_in [*8] ##0 (!osb_q && !$past(osb_q)) |->
		serial_output_enable_out == '0) else $error("outputs driven in standby");
	AST_DRIVE_PIN: assert property (output_drive_enable_pin_in [*8] |-> &serial_output_enable_out)
		else $error("outputs off with pin high");
	AST_DRIVE_BIT: assert property (osb_q && $past(osb_q) |-> &serial_output_enable_out)
		else $error("outputs off with standby bit set");
	AST_RATE: assert property (serial_rate_out == rate_enc($past(rate_q)))
		else $error("rate decode wrong");
endmodule : interface_mode_select_checker
`default_nettype wire

// ==== verification/host_model.sv ====
// Host processor model issuing register accesses.
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic core_clk_in, // Clock.
	output logic host_sel_out, // Strobe.
	output logic host_wr_out, // Write.
	output logic [7:0] host_addr_out, // Address.
	output logic [15:0] host_wdata_out, // Write data.
	input wire logic [15:0] host_rdata_in, // Read data.
	input wire logic host_rd_hit_in // Read hit.
);
	initial begin
		host_sel_out = 1'b0;
		host_wr_out = 1'b0;
		host_addr_out = 8'h00;
		host_wdata_out = 16'h0000;
	end
	// Bits 9 to 2 go in one write, so begin and fill data always land together; bits 15 to 10 go as zeros and rate code 3 as 0.
	task write_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		host_sel_out <= 1'b1;
		host_wr_out <= 1'b1;
		host_addr_out <= a;
		host_wdata_out <= {6'h00, d[9:2], (d[1:0] == 2'h3) ? 2'h0 : d[1:0]};
		@(posedge core_clk_in);
		host_sel_out <= 1'b0;
		host_wdata_out <= ~host_wdata_out;
	endtask : write_reg
	task read_reg(input logic [7:0] a, output logic [15:0] d, output logic h);
		@(posedge core_clk_in);
		host_sel_out <= 1'b1;
		host_wr_out <= 1'b0;
		host_addr_out <= a;
		@(posedge core_clk_in);
		host_sel_out <= 1'b0;
		@(posedge core_clk_in);
		d = host_rdata_in;
		h = host_rd_hit_in;
	endtask : read_reg
endmodule : host_model
`default_nettype wire

// ==== verification/interface_mode_select_tb.sv ====
// Testbench for the interface mode selection block.
`timescale 1ns/1ns
`default_nettype none
module interface_mode_select_tb;
	import ims_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ready = 1'b0, frame = 1'b0, pin = 1'b0, cmpl = 1'b0;
	logic sel, wr, hit, busy, est, act, clr;
	logic [7:0] addr;
	logic [15:0] wd, rd, en, d;
	logic h;
	logic [5:0] fc = 6'h00;
	cm_write_t cmw;
	serial_rate_t rate;
	int mismatches = 0, checked = 0, words = 0, n0, i;
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		fc <= (fc == 6'd39) ? 6'd0 : fc + 6'd1;
		frame <= (fc == 6'd39);
		if (cmw.wr_en === 1'b1) words <= words + 1;
	end
	host_model host (.core_clk_in(clk), .host_sel_out(sel), .host_wr_out(wr), .host_addr_out(addr),
		.host_wdata_out(wd), .host_rdata_in(rd), .host_rd_hit_in(hit));
	interface_mode_select #(.CM_DEPTH(16)) DUT (.core_clk_in(clk), .rst_n_in(rst_n), .host_sel_in(sel),
		.host_wr_in(wr), .host_addr_in(addr), .host_wdata_in(wd), .host_rdata_out(rd),
		.host_rd_hit_out(hit), .block_fill_ready_in(ready), .frame_start_in(frame),
		.output_drive_enable_pin_in(pin), .offset_evaluation_complete_in(cmpl), .cm_write_out(cmw),
		.block_fill_busy_out(busy), .serial_output_enable_out(en), .offset_eval_start_out(est),
		.offset_eval_active_out(act), .offset_eval_clear_out(clr), .serial_rate_out(rate));
	task check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task end_of_test;
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	task rd_check(input logic [7:0] a, input logic [15:0] exp, input logic exp_hit);
		host.read_reg(a, d, h);
		check(d, exp);
		check({15'h0000, h}, {15'h0000, exp_hit});
	endtask : rd_check
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd_check(8'h01, 16'h0000, 1'b1);
		rd_check(8'h02, 16'h0000, 1'b0);
		host.write_reg(8'h00, 16'h03FF);
		rd_check(8'h01, 16'h0000, 1'b1);
		for (i = 0; i < 3; i++) begin
			host.write_reg(8'h01, 16'(i));
			repeat (3) @(posedge clk);
			check({13'h0000, rate}, 16'h0001 << i);
			rd_check(8'h01, 16'(i), 1'b1);
		end
		host.write_reg(8'h01, 16'h0008);
		repeat (3) @(posedge clk);
		check(en, 16'hFFFF);
		host.write_reg(8'h01, 16'h0000);
		repeat (3) @(posedge clk);
		check(en, 16'h0000);
		pin <= 1'b1;
		repeat (8) @(posedge clk);
		check(en, 16'hFFFF);
		pin <= 1'b0;
		host.write_reg(8'h01, 16'h0004);
		repeat (2) @(posedge clk);
		check({15'h0000, act}, 16'h0001);
		cmpl <= 1'b1;
		repeat (2) @(posedge clk);
		check({15'h0000, act}, 16'h0000);
		host.write_reg(8'h01, 16'h0000);
		cmpl <= 1'b0;
		repeat (40) @(posedge clk);
		host.write_reg(8'h01, 16'h02B0);
		repeat (4) @(posedge clk);
		check({15'h0000, busy}, 16'h0000);
		host.write_reg(8'h01, 16'h0000);
		ready <= 1'b1;
		n0 = words;
		host.write_reg(8'h01, 16'h02B0);
		// Busy only shows after the edge that takes the write, so let it settle before polling.
		@(posedge clk);
		for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
		check(16'(words - n0), 16'd16);
		check({15'h0000, i >= 40}, 16'h0001);
		rd_check(8'h01, 16'h02A0, 1'b1);
		host.write_reg(8'h01, 16'h02B0);
		repeat (4) @(posedge clk);
		host.write_reg(8'h01, 16'h02A0);
		repeat (3) @(posedge clk);
		n0 = words;
		check({15'h0000, busy}, 16'h0000);
		repeat (20) @(posedge clk);
		check(16'(words), 16'(n0));
		host.write_reg(8'h01, 16'h02B0);
		repeat (4) @(posedge clk);
		ready <= 1'b0;
		repeat (3) @(posedge clk);
		check({15'h0000, busy}, 16'h0000);
		rd_check(8'h01, 16'h02A0, 1'b1);
		end_of_test;
	end
endmodule : interface_mode_select_tb
bind interface_mode_select interface_mode_select_checker #(.CM_DEPTH(CM_DEPTH), .FILL_FRAMES(FILL_FRAMES),
	.SERIAL_OUTPUTS(SERIAL_OUTPUTS)) chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.host_sel_in(host_sel_in), .host_wr_in(host_wr_in), .host_addr_in(host_addr_in),
	.host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out), .host_rd_hit_out(host_rd_hit_out),
	.block_fill_ready_in(block_fill_ready_in), .frame_start_in(frame_start_in),
	.output_drive_enable_pin_in(output_drive_enable_pin_in),
	.offset_evaluation_complete_in(offset_evaluation_complete_in), .cm_write_out(cm_write_out),
	.block_fill_busy_out(block_fill_busy_out), .serial_output_enable_out(serial_output_enable_out),
	.offset_eval_start_out(offset_eval_start_out), .offset_eval_active_out(offset_eval_active_out),
	.offset_eval_clear_out(offset_eval_clear_out), .serial_rate_out(serial_rate_out));
`default_nettype wire
